/* File: verilog/sensor_regs_pkg.sv */
package sensor_regs_pkg;

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [7:0] IDX_SENSOR_STATUS        = 8'h03;
	localparam logic [7:0] IDX_AUX_R_HIGH           = 8'h11;
	localparam logic [7:0] IDX_ACCEL_X_LOW          = 8'h12;
	localparam logic [7:0] IDX_ACCEL_X_HIGH         = 8'h13;
	localparam logic [7:0] IDX_ACCEL_Y_LOW          = 8'h14;
	localparam logic [7:0] IDX_ACCEL_Y_HIGH         = 8'h15;
	localparam logic [7:0] IDX_ACCEL_Z_LOW          = 8'h16;
	localparam logic [7:0] IDX_ACCEL_Z_HIGH         = 8'h17;
	localparam logic [7:0] IDX_TIMESTAMP_LOW        = 8'h18;
	localparam logic [7:0] IDX_TIMESTAMP_MID        = 8'h19;
	localparam logic [7:0] IDX_TIMESTAMP_HIGH       = 8'h1a;
	localparam logic [7:0] IDX_POWER_UP_EVENT       = 8'h1b;
	localparam logic [7:0] IDX_FEATURE_IRQ_STATUS   = 8'h1c;
	localparam logic [7:0] IDX_READY_FIFO_IRQ_STATUS = 8'h1d;
	localparam logic [7:0] IDX_STEPS_BYTE0          = 8'h1e;
	localparam logic [7:0] IDX_STEPS_BYTE1          = 8'h1f;
	localparam logic [7:0] IDX_STEPS_BYTE2          = 8'h20;
	localparam logic [7:0] IDX_STEPS_BYTE3          = 8'h21;
	localparam logic [7:0] IDX_DIE_TEMPERATURE      = 8'h22;

	// Bus geometry.
	localparam int ADR_W   = 8;
	localparam int DAT_W   = 32;
	localparam int SEL_W   = 4;
	localparam int IDX_LSB = 2;

	// Field positions.
	localparam int STATUS_DRDY_ACC_BIT = 7;
	localparam int STATUS_DRDY_AUX_BIT = 5;
	localparam int EVENT_POR_BIT       = 0;
	localparam int IRQ_FFULL_BIT       = 0;
	localparam int IRQ_FWM_BIT         = 1;
	localparam int IRQ_AUX_DRDY_BIT    = 5;
	localparam int IRQ_ACC_DRDY_BIT    = 7;

	// Reset values.
	localparam logic [7:0] RST_DATA        = 8'h00;
	localparam logic [7:0] RST_EVENT       = 8'h01;
	localparam logic [7:0] RST_IRQ_STATUS  = 8'h00;
	localparam logic [7:0] RST_STATUS      = 8'h00;
	localparam logic [23:0] RST_TIMESTAMP  = 24'h000000;

	// Temperature code zero stands for this many degrees Celsius, one kelvin a step.
	localparam int TEMP_ZERO_CELSIUS = 23;

	// Timestamp timing. One count lasts 39.0625 us, which is 1562.5 cycles at 40 MHz,
	// so the prescaler counts half cycles to stay exact on average.
	localparam real CLK_MHZ            = 40.0;
	localparam real TS_LSB_US          = 39.0625;
	localparam int  TS_HALF_CYCLES     = int'(2.0 * TS_LSB_US * CLK_MHZ);
	localparam int  TS_PRESCALE_W      = 12;
	localparam int  TS_W               = 24;

	typedef struct packed {
		logic             cyc;
		logic             stb;
		logic             we;
		logic [ADR_W-1:0] adr;
		logic [SEL_W-1:0] sel;
		logic [DAT_W-1:0] dat;
	} wb_req_t;

	typedef struct packed {
		logic             ack;
		logic [DAT_W-1:0] dat;
	} wb_rsp_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] x;
		logic [15:0] y;
		logic [15:0] z;
	} accel_sample_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] r;
	} aux_sample_t;

	typedef struct packed {
		logic full;
		logic watermark;
	} fifo_events_t;

endpackage : sensor_regs_pkg

/* File: verilog/timestamp_counter.sv */
module timestamp_counter (
	// Clock and reset.
	input  wire logic                               clock,
	input  wire logic                               arst_n,
	// Restart from zero.
	input  wire logic                               restart,
	// Count value.
	output logic [sensor_regs_pkg::TS_W-1:0]        count
);

	logic [sensor_regs_pkg::TS_PRESCALE_W-1:0] half_r;
	logic [sensor_regs_pkg::TS_PRESCALE_W-1:0] half_nxt;
	logic                                      tick;

	localparam logic [sensor_regs_pkg::TS_PRESCALE_W-1:0] HALF_STEP = 12'h002;
	localparam logic [sensor_regs_pkg::TS_PRESCALE_W-1:0] HALF_WRAP =
		sensor_regs_pkg::TS_PRESCALE_W'(sensor_regs_pkg::TS_HALF_CYCLES);

	// Two half cycles per clock; a count is due once the total reaches the period.
	always_comb begin
		half_nxt = half_r + HALF_STEP;
		tick     = 1'b0;
		if (half_nxt >= HALF_WRAP) begin
			half_nxt = half_nxt - HALF_WRAP;
			tick     = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			half_r <= '0;
		end else if (restart) begin
			half_r <= '0;
		end else begin
			half_r <= half_nxt;
		end
	end

	// Free count; the top wraps to zero by plain overflow.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			count <= sensor_regs_pkg::RST_TIMESTAMP;
		end else if (restart) begin
			count <= sensor_regs_pkg::RST_TIMESTAMP;
		end else if (tick) begin
			count <= count + 24'h000001;
		end
	end

endmodule : timestamp_counter

/* File: verilog/sensor_output_register_bank.sv */
module sensor_output_register_bank (
	// Clock and reset.
	input  wire logic                            clock,
	input  wire logic                            arst_n,
	// Soft reset request from the command logic, one cycle.
	input  wire logic                            soft_reset,
	// Register bus.
	input  wire sensor_regs_pkg::wb_req_t        wb_req,
	output sensor_regs_pkg::wb_rsp_t             wb_rsp,
	// Sensor results.
	input  wire sensor_regs_pkg::accel_sample_t  accel_sample,
	input  wire sensor_regs_pkg::aux_sample_t    aux_sample,
	input  wire sensor_regs_pkg::fifo_events_t   fifo_events,
	input  wire logic [7:0]                      temperature_code,
	// Feature engine results.
	input  wire logic [7:0]                      feature_irq_flags,
	input  wire logic [31:0]                     step_count,
	// Status seen by the rest of the device.
	output logic                                 accel_ready,
	output logic                                 aux_ready
);

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} bus_state_t;

	bus_state_t        bus_r;
	bus_state_t        bus_nxt;

	logic [7:0]        idx;
	logic              req_new;
	logic              rd_new;
	logic              mapped;
	logic [7:0]        rd_byte;

	logic [15:0]       accel_x_r;
	logic [15:0]       accel_y_r;
	logic [15:0]       accel_z_r;
	logic [15:0]       aux_r_r;
	logic [7:0]        temperature_r;
	logic [7:0]        feature_irq_r;
	logic [31:0]       steps_r;

	logic              drdy_acc_r;
	logic              drdy_aux_r;
	logic              por_r;
	logic [7:0]        irq_status_r;
	logic [7:0]        irq_set;
	logic [7:0]        dat_r;
	logic              ack_r;

	logic [sensor_regs_pkg::TS_W-1:0] timestamp;

	logic              rd_accel;
	logic              rd_aux;
	logic              rd_event;
	logic              rd_irq_status;

	// Word index from the byte address; the two low address bits select nothing.
	assign idx     = {2'b00, wb_req.adr[sensor_regs_pkg::ADR_W-1:sensor_regs_pkg::IDX_LSB]};
	assign req_new = wb_req.cyc && wb_req.stb && (bus_r == BUS_IDLE);
	assign rd_new  = req_new && !wb_req.we;

	// Read side effects happen on the edge that samples the register, so an event that
	// lands later is kept for the next read rather than swallowed.
	assign rd_accel      = rd_new && (idx >= sensor_regs_pkg::IDX_ACCEL_X_LOW) &&
	                       (idx <= sensor_regs_pkg::IDX_ACCEL_Z_HIGH);
	assign rd_aux        = rd_new && (idx == sensor_regs_pkg::IDX_AUX_R_HIGH);
	assign rd_event      = rd_new && (idx == sensor_regs_pkg::IDX_POWER_UP_EVENT);
	assign rd_irq_status = rd_new && (idx == sensor_regs_pkg::IDX_READY_FIFO_IRQ_STATUS);

	timestamp_counter u_timestamp (
		.clock   (clock),
		.arst_n  (arst_n),
		.restart (soft_reset),
		.count   (timestamp)
	);

	// Bus handshake: every request is answered one cycle after it is seen.
	always_comb begin
		bus_nxt = bus_r;
		unique case (bus_r)
			BUS_IDLE: begin
				if (wb_req.cyc && wb_req.stb) begin
					bus_nxt = BUS_ACK;
				end
			end
			BUS_ACK: begin
				bus_nxt = BUS_IDLE;
			end
			default: begin
				bus_nxt = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			bus_r <= BUS_IDLE;
		end else begin
			bus_r <= bus_nxt;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req_new;
		end
	end

	// Result capture. Writes from the bus never reach these registers.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			accel_x_r <= {sensor_regs_pkg::RST_DATA, sensor_regs_pkg::RST_DATA};
			accel_y_r <= {sensor_regs_pkg::RST_DATA, sensor_regs_pkg::RST_DATA};
			accel_z_r <= {sensor_regs_pkg::RST_DATA, sensor_regs_pkg::RST_DATA};
		end else if (soft_reset) begin
			accel_x_r <= {sensor_regs_pkg::RST_DATA, sensor_regs_pkg::RST_DATA};
			accel_y_r <= {sensor_regs_pkg::RST_DATA, sensor_regs_pkg::RST_DATA};
			accel_z_r <= {sensor_regs_pkg::RST_DATA, sensor_regs_pkg::RST_DATA};
		end else if (accel_sample.valid) begin
			accel_x_r <= accel_sample.x;
			accel_y_r <= accel_sample.y;
			accel_z_r <= accel_sample.z;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			aux_r_r <= {sensor_regs_pkg::RST_DATA, sensor_regs_pkg::RST_DATA};
		end else if (soft_reset) begin
			aux_r_r <= {sensor_regs_pkg::RST_DATA, sensor_regs_pkg::RST_DATA};
		end else if (aux_sample.valid) begin
			aux_r_r <= aux_sample.r;
		end
	end

	// Temperature is passed on in its own code; no offset is applied here.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			temperature_r <= sensor_regs_pkg::RST_DATA;
		end else if (soft_reset) begin
			temperature_r <= sensor_regs_pkg::RST_DATA;
		end else begin
			temperature_r <= temperature_code;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			feature_irq_r <= sensor_regs_pkg::RST_DATA;
			steps_r       <= '0;
		end else if (soft_reset) begin
			feature_irq_r <= sensor_regs_pkg::RST_DATA;
			steps_r       <= '0;
		end else begin
			feature_irq_r <= feature_irq_flags;
			steps_r       <= step_count;
		end
	end

	// Data ready flags; a new sample in the read cycle keeps the flag set.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			drdy_acc_r <= 1'b0;
		end else if (soft_reset) begin
			drdy_acc_r <= 1'b0;
		end else if (accel_sample.valid) begin
			drdy_acc_r <= 1'b1;
		end else if (rd_accel) begin
			drdy_acc_r <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			drdy_aux_r <= 1'b0;
		end else if (soft_reset) begin
			drdy_aux_r <= 1'b0;
		end else if (aux_sample.valid) begin
			drdy_aux_r <= 1'b1;
		end else if (rd_aux) begin
			drdy_aux_r <= 1'b0;
		end
	end

	// Power-up flag.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			por_r <= sensor_regs_pkg::RST_EVENT[sensor_regs_pkg::EVENT_POR_BIT];
		end else if (soft_reset) begin
			por_r <= 1'b1;
		end else if (rd_event) begin
			por_r <= 1'b0;
		end
	end

	// Interrupt status events, one bit each.
	always_comb begin
		irq_set = 8'h00;
		irq_set[sensor_regs_pkg::IRQ_FFULL_BIT]    = fifo_events.full;
		irq_set[sensor_regs_pkg::IRQ_FWM_BIT]      = fifo_events.watermark;
		irq_set[sensor_regs_pkg::IRQ_AUX_DRDY_BIT] = aux_sample.valid;
		irq_set[sensor_regs_pkg::IRQ_ACC_DRDY_BIT] = accel_sample.valid;
	end

	// Clear on read, with any event of that same cycle surviving the clear.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			irq_status_r <= sensor_regs_pkg::RST_IRQ_STATUS;
		end else if (soft_reset) begin
			irq_status_r <= sensor_regs_pkg::RST_IRQ_STATUS;
		end else if (rd_irq_status) begin
			irq_status_r <= irq_set;
		end else begin
			irq_status_r <= irq_status_r | irq_set;
		end
	end

	// Read multiplexer.
	always_comb begin
		rd_byte = 8'h00;
		mapped  = 1'b1;
		unique case (idx)
			sensor_regs_pkg::IDX_SENSOR_STATUS: begin
				rd_byte[sensor_regs_pkg::STATUS_DRDY_ACC_BIT] = drdy_acc_r;
				rd_byte[sensor_regs_pkg::STATUS_DRDY_AUX_BIT] = drdy_aux_r;
			end
			sensor_regs_pkg::IDX_AUX_R_HIGH:       rd_byte = aux_r_r[15:8];
			sensor_regs_pkg::IDX_ACCEL_X_LOW:      rd_byte = accel_x_r[7:0];
			sensor_regs_pkg::IDX_ACCEL_X_HIGH:     rd_byte = accel_x_r[15:8];
			sensor_regs_pkg::IDX_ACCEL_Y_LOW:      rd_byte = accel_y_r[7:0];
			sensor_regs_pkg::IDX_ACCEL_Y_HIGH:     rd_byte = accel_y_r[15:8];
			sensor_regs_pkg::IDX_ACCEL_Z_LOW:      rd_byte = accel_z_r[7:0];
			sensor_regs_pkg::IDX_ACCEL_Z_HIGH:     rd_byte = accel_z_r[15:8];
			sensor_regs_pkg::IDX_TIMESTAMP_LOW:    rd_byte = timestamp[7:0];
			sensor_regs_pkg::IDX_TIMESTAMP_MID:    rd_byte = timestamp[15:8];
			sensor_regs_pkg::IDX_TIMESTAMP_HIGH:   rd_byte = timestamp[23:16];
			sensor_regs_pkg::IDX_POWER_UP_EVENT: begin
				rd_byte[sensor_regs_pkg::EVENT_POR_BIT] = por_r;
			end
			sensor_regs_pkg::IDX_FEATURE_IRQ_STATUS:    rd_byte = feature_irq_r;
			sensor_regs_pkg::IDX_READY_FIFO_IRQ_STATUS: rd_byte = irq_status_r;
			sensor_regs_pkg::IDX_STEPS_BYTE0:      rd_byte = steps_r[7:0];
			sensor_regs_pkg::IDX_STEPS_BYTE1:      rd_byte = steps_r[15:8];
			sensor_regs_pkg::IDX_STEPS_BYTE2:      rd_byte = steps_r[23:16];
			sensor_regs_pkg::IDX_STEPS_BYTE3:      rd_byte = steps_r[31:24];
			sensor_regs_pkg::IDX_DIE_TEMPERATURE:  rd_byte = temperature_r;
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// Read data is captured with the request; unmapped addresses and writes give zero.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			dat_r <= 8'h00;
		end else if (rd_new && mapped) begin
			dat_r <= rd_byte;
		end else if (req_new) begin
			dat_r <= 8'h00;
		end
	end

	assign wb_rsp.ack = ack_r;
	assign wb_rsp.dat = {24'h000000, dat_r};
	assign accel_ready = drdy_acc_r;
	assign aux_ready   = drdy_aux_r;

endmodule : sensor_output_register_bank

/* File: tb/wb_host.sv */
module wb_host (
	// Clock.
	input  wire logic                     clock,
	// Register bus.
	output sensor_regs_pkg::wb_req_t      wb_req,
	input  wire sensor_regs_pkg::wb_rsp_t wb_rsp
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		wb_req = '0;
	end

	// The request is held until ack is sampled or 50 edges pass, so an answer within that never loses it.
	task automatic xfer(input logic we, input logic [7:0] adr, output logic [31:0] d,
		output logic ok);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: $urandom};
		ok = 1'b0;
		for (int n = 0; n < 50 && ok !== 1'b1; n++) begin
			@(posedge clock);
			ok = (wb_rsp.ack === 1'b1);
		end
		d = wb_rsp.dat;
		wb_req <= '0;
		@(posedge clock);
	endtask : xfer
endmodule : wb_host

/* File: tb/sensor_bank_checker.sv */
module sensor_bank_checker (
	// Clock and reset.
	input wire logic                           clock,
	input wire logic                           arst_n,
	input wire logic                           soft_reset,
	// Watched ports.
	input wire sensor_regs_pkg::wb_req_t       wb_req,
	input wire sensor_regs_pkg::wb_rsp_t       wb_rsp,
	input wire sensor_regs_pkg::accel_sample_t accel_sample,
	input wire sensor_regs_pkg::aux_sample_t   aux_sample,
	input wire sensor_regs_pkg::fifo_events_t  fifo_events,
	input wire logic [7:0]                     temperature_code,
	input wire logic                           accel_ready,
	input wire logic                           aux_ready
);
	logic take;
	logic rd;
	logic ev;
	assign take = wb_req.cyc && wb_req.stb && !wb_rsp.ack && !soft_reset;
	assign rd = take && !wb_req.we;
	assign ev = fifo_events.full || fifo_events.watermark || accel_sample.valid || aux_sample.valid;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	sequence s_twice_ev;
		(rd && wb_req.adr == 8'h6c) ##1 !soft_reset [*2] ##1 (rd && wb_req.adr == 8'h6c);
	endsequence
	sequence s_quiet_irq;
		(rd && wb_req.adr == 8'h74 && !ev) ##1 !ev [*2] ##1 (rd && wb_req.adr == 8'h74 && !ev);
	endsequence

	a_ack_pulse: assert property (take |=> wb_rsp.ack ##1 !wb_rsp.ack)
		else $error("ack not a single cycle after request");
	a_upper_zero: assert property (wb_rsp.ack |-> wb_rsp.dat[31:8] == 24'h0)
		else $error("upper read data bits set");
	a_write_ignored: assert property (take && wb_req.we |=> wb_rsp.dat == 32'h0)
		else $error("write answered with data");
	a_event_clears: assert property (s_twice_ev |=> wb_rsp.dat == 32'h0)
		else $error("power-up flag survived a read");
	a_irq_clears: assert property (s_quiet_irq |=> wb_rsp.dat == 32'h0)
		else $error("status flags survived a read");
	a_accel_sets: assert property (accel_sample.valid && !soft_reset |=> accel_ready)
		else $error("accel ready not set");
	a_accel_clears: assert property (rd && wb_req.adr inside {[8'h48:8'h5c]}
		&& wb_req.adr[1:0] == 2'h0 && !accel_sample.valid |=> !accel_ready)
		else $error("accel ready not cleared by read");
	a_aux_sets: assert property (aux_sample.valid && !soft_reset |=> aux_ready)
		else $error("aux ready not set");
	a_aux_clears: assert property (rd && wb_req.adr == 8'h44 && !aux_sample.valid
		|=> !aux_ready)
		else $error("aux ready not cleared by read");
	a_temp_read: assert property (rd && wb_req.adr == 8'h88 && $stable(temperature_code)
		|=> wb_rsp.dat[7:0] == $past(temperature_code))
		else $error("temperature code altered");
endmodule : sensor_bank_checker

/* File: tb/testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic                           clock;
	logic                           arst_n;
	logic                           soft_reset;
	sensor_regs_pkg::wb_req_t       wb_req;
	sensor_regs_pkg::wb_rsp_t       wb_rsp;
	sensor_regs_pkg::accel_sample_t accel_sample;
	sensor_regs_pkg::aux_sample_t   aux_sample;
	sensor_regs_pkg::fifo_events_t  fifo_events;
	logic [7:0]                     temperature_code;
	logic [7:0]                     feature_irq_flags;
	logic [31:0]                    step_count;
	logic                           accel_ready;
	logic                           aux_ready;
	int                             err_count = 0;
	int                             total_checks = 0;
	int                             cycle = 0;
	logic [31:0]                    rdat;
	logic                           ok;
	logic [7:0]                     irq_exp [4] = '{8'h01, 8'h02, 8'h20, 8'h80};

	wb_host i_host (.clock(clock), .wb_req(wb_req), .wb_rsp(wb_rsp));
	sensor_output_register_bank i_dut (.clock(clock), .arst_n(arst_n),
		.soft_reset(soft_reset), .wb_req(wb_req), .wb_rsp(wb_rsp),
		.accel_sample(accel_sample), .aux_sample(aux_sample), .fifo_events(fifo_events),
		.temperature_code(temperature_code), .feature_irq_flags(feature_irq_flags),
		.step_count(step_count), .accel_ready(accel_ready), .aux_ready(aux_ready));

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock) cycle <= cycle + 1;

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check

	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic bus(input logic we, input logic [7:0] idx);
		i_host.xfer(we, {idx[5:0], 2'h0}, rdat, ok);
		if (ok !== 1'b1) begin
			err_count++;
			$display("unexpected at %0t: ack %h, expected %h at index %h", $time, ok, 1'b1, idx);
			report_and_stop();
		end
	endtask : bus

	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		bus(1'b0, idx);
		check(rdat, {24'h0, exp});
	endtask : rd

	// Event inputs are one-cycle pulses; the second edge lets the flags land first.
	task automatic pulse(input int k);
		case (k)
			0: fifo_events.full <= 1'b1;
			1: fifo_events.watermark <= 1'b1;
			2: aux_sample.valid <= 1'b1;
			3: accel_sample.valid <= 1'b1;
			default: ;
		endcase
		@(posedge clock);
		fifo_events <= '0;
		aux_sample.valid <= 1'b0;
		accel_sample.valid <= 1'b0;
		@(posedge clock);
	endtask : pulse

	function automatic logic [7:0] exp_reset(input logic [7:0] idx);
		case (idx)
			8'h1b: return sensor_regs_pkg::RST_EVENT;
			8'h1c: return feature_irq_flags;
			8'h1e, 8'h1f, 8'h20, 8'h21: return step_count[8 * (idx - 8'h1e) +: 8];
			8'h22: return temperature_code;
			default: return sensor_regs_pkg::RST_DATA;
		endcase
	endfunction : exp_reset

	function automatic logic [7:0] acc_byte(input logic [47:0] v, input int i);
		logic [15:0] w;
		w = v[47 - 16 * (i / 2) -: 16];
		return (i % 2) ? w[15:8] : w[7:0];
	endfunction : acc_byte

	function automatic logic [23:0] ts_count(input int c);
		return 24'((2 * c) / 3125);
	endfunction : ts_count

	initial begin
		logic [47:0] v;
		logic [15:0] r;
		int          t0;
		int          tgt;
		void'($urandom(6));
		arst_n = 1'b0;
		{soft_reset, accel_sample, aux_sample, fifo_events, temperature_code} = '0;
		feature_irq_flags = 8'($urandom);
		step_count = $urandom;
		repeat (4) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		for (int i = 0; i < 8'h31; i++) rd(8'(i), exp_reset(8'(i)));
		rd(8'h1b, 8'h00);
		rd(8'h1d, 8'h00);
		$display("test 1 done");
		for (int n = 0; n < 3; n++) begin
			v = {16'($urandom), 16'($urandom), 16'($urandom)};
			accel_sample <= {1'b1, v};
			pulse(4);
			check({31'h0, accel_ready}, 32'h1);
			rd(8'h03, 8'h80);
			for (int i = 0; i < 6; i++) rd(8'h12 + 8'(i), acc_byte(v, i));
			check({31'h0, accel_ready}, 32'h0);
		end
		$display("test 2 done");
		r = 16'($urandom);
		aux_sample <= '{valid: 1'b1, r: r};
		pulse(4);
		check({31'h0, aux_ready}, 32'h1);
		rd(8'h03, 8'h20);
		rd(8'h11, r[15:8]);
		check({31'h0, aux_ready}, 32'h0);
		$display("test 3 done");
		bus(1'b0, 8'h1d);
		for (int k = 0; k < 4; k++) begin
			pulse(k);
			rd(8'h1d, irq_exp[k]);
			rd(8'h1d, 8'h00);
		end
		$display("test 4 done");
		for (int i = 0; i < 6; i++) begin
			temperature_code <= (i < 2) ? 8'h7f + 8'(i) : 8'($urandom);
			@(posedge clock);
			rd(8'h22, temperature_code);
		end
		$display("test 5 done");
		soft_reset <= 1'b1;
		t0 = cycle;
		@(posedge clock);
		soft_reset <= 1'b0;
		@(posedge clock);
		bus(1'b1, 8'h1b);
		rd(8'h1b, sensor_regs_pkg::RST_EVENT);
		rd(8'h1b, 8'h00);
		for (int k = 0; k < 4; k++) begin
			// One read lands on the first tick so an off-by-one count shows.
			tgt = (k == 1) ? 1564 : k * 1563 + 500 + $urandom_range(400);
			while (cycle - t0 < tgt) @(posedge clock);
			for (int b = 0; b < 3; b++) begin
				// Restart takes effect one edge after t0, so the count seen lags by one.
				rd(8'h18 + 8'(b), 8'(ts_count(cycle - t0 - 1) >> (8 * b)));
			end
		end
		$display("test 6 done");
		report_and_stop();
	end
endmodule : testbench

bind sensor_output_register_bank sensor_bank_checker i_chk (.clock(clock), .arst_n(arst_n),
	.soft_reset(soft_reset), .wb_req(wb_req), .wb_rsp(wb_rsp), .accel_sample(accel_sample),
	.aux_sample(aux_sample), .fifo_events(fifo_events), .temperature_code(temperature_code),
	.accel_ready(accel_ready), .aux_ready(aux_ready));
